/* hw/admdr_defines.vh */
// constants for the main digital control register bank
`ifndef ADMDR_DEFINES_VH
`define ADMDR_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ADMDR_IDX_FMODE     8'h41
`define ADMDR_IDX_ZONE      8'h42
`define ADMDR_IDX_GAINV     8'h44
`define ADMDR_IDX_DECIM     8'h4D
`define ADMDR_IDX_ZONE_EN   8'h4E
`define ADMDR_IDX_GAIN_CTL  8'h52
`define ADMDR_IDX_REO_COMP  8'h72
`define ADMDR_IDX_REO_MAP   8'h73
`define ADMDR_IDX_LSB_EN    8'hAB
`define ADMDR_IDX_LSB_SRC   8'hAD
`define ADMDR_IDX_DIG_RST   8'hF7
`define ADMDR_IDX_STATUS    8'hF0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADMDR_BIT_DEC_EN    3
`define ADMDR_BIT_FMODE_HI  4
`define ADMDR_BIT_ZONE_EN   7
`define ADMDR_BIT_GAIN_EN   0
`define ADMDR_BIT_REO_A     7
`define ADMDR_BIT_REO_B     3
`define ADMDR_BIT_LSB_EN    0
`define ADMDR_BIT_DIG_RST   0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define ADMDR_RST_BYTE      8'h00
`define ADMDR_RST_WORD      32'h0000_0000
`define ADMDR_FMODE_LP      4'hA
`define ADMDR_FMODE_HP      4'hE
`define ADMDR_ZONE_FIRST    3'h0
`define ADMDR_ZONE_THIRD    3'h2
`define ADMDR_GAIN_UNITY    7'h20
`define ADMDR_LSB_FULL      2'h0
`define ADMDR_LSB_FAST_OVERRANGE_FLAG      2'h3

`endif

/* hw/admdr_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module admdr_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] level
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer         i;

    // first stage feeds only the second one
    always @(posedge mclk) begin
        if (rst) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            level  <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

endmodule // admdr_sync

/* hw/admdr_chan.v */
// one output channel: lsb replacement by fast overrange
`timescale 1ns/100ps
module admdr_chan (
    input  wire        mclk,
    input  wire        rst,
    input  wire        clr,
    input  wire [15:0] data_in,
    input  wire        fast_overrange_flag,
    input  wire        replace_lsb,
    output reg  [15:0] data_out
);

    // clr is the self-clearing logic reset; flushes the output word
    always @(posedge mclk) begin
        if (rst || clr) begin
            data_out <= 16'h0000;
        end else if (replace_lsb) begin
            data_out <= {data_in[15:1], fast_overrange_flag}; // R6
        end else begin
            data_out <= data_in; // R6
        end
    end

endmodule // admdr_chan

/* hw/admdr_regs.v */
// main digital control register bank with wishbone slave
`timescale 1ns/100ps
`include "admdr_defines.vh"

// Summary of operation
// R1 - decimation enable bit 3 decides if filter mode field drives filter
// R2 - zone enable bit 7 decides if zone field reaches interleave correction
// R3 - gain enable bit 0 passes programmed gain, else gain disabled
// R4 - reorder active only when both write-only reorder bits are set
// R5 - low-bit override enable lets source field put overrange on lsb
// R6 - source 00 passes full data, 11 puts each overrange flag on lsb
// R7 - writing 1 to reset bit pulses logic reset, zone logic untouched
// R8 - software writes zero to reserved bits; all fields reset to zero
// R9 - filter low-pass by default; 1010 low-pass, 1110 high-pass, else bad
// R10 - zone codes 000, 001, 010 are first, second, third zone
// R11 - seven-bit gain scales data as 20 log10(value / 32) dB
// R12 - reset bit clears itself one cycle after the write
module admdr_regs (
    input  wire        mclk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [15:0] ch_a_data_in,
    input  wire [15:0] ch_b_data_in,
    input  wire [1:0]  fast_overrange_pin,
    output wire [15:0] ch_a_data_out,
    output wire [15:0] ch_b_data_out,
    output reg         filter_highpass,
    output reg         filter_mode_bad,
    output reg         zone_select_active,
    output reg  [2:0]  zone_applied,
    output reg         gain_active,
    output reg  [6:0]  gain_applied,
    output reg         reorder_active,
    output reg  [7:0]  lane_reorder_map_out,
    output reg         logic_block_reset
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg        decimation_ctrl_enable;
    reg  [3:0] filter_mode_select;
    reg        zone_enable;
    reg  [2:0] zone_code;
    reg  [6:0] gain_value;
    reg        gain_enable;
    reg        reorder_wo_gain;
    reg        reorder_wo_comp;
    reg  [7:0] lane_reorder_map;
    reg        low_bit_enable;
    reg  [1:0] low_bit_source;
    reg        reset_pending;
    reg        replace_lsb;

    wire [7:0] reg_index;
    wire [7:0] wr_byte;
    wire       bus_req;
    wire       wr_commit;
    wire [1:0] fast_overrange_flag;
    reg  [7:0] next_rd_byte;

    assign reg_index = wb_adr_i[9:2];
    assign wr_byte   = wb_dat_i[7:0];
    assign bus_req   = wb_cyc_i && wb_stb_i;
    // writes land on the edge where the master sees ack high
    assign wr_commit = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];

    // ------------------------------------------------------------
    // overrange pins come from outside the clock domain
    // ------------------------------------------------------------
    admdr_sync #(
        .WIDTH (2)
    ) u_fast_overrange_flag_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin   (fast_overrange_pin),
        .level (fast_overrange_flag)
    );

    // ------------------------------------------------------------
    // bus handshake: one wait state, ack drops after one cycle
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `ADMDR_RST_WORD;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= {24'h000000, next_rd_byte};
            end else begin
                wb_dat_o <= `ADMDR_RST_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // read decode; write-only bits and unmapped indices read zero
    // ------------------------------------------------------------
    always @* begin
        next_rd_byte = `ADMDR_RST_BYTE;
        if (reg_index == `ADMDR_IDX_FMODE) begin
            next_rd_byte[`ADMDR_BIT_FMODE_HI] = filter_mode_select[3];
            next_rd_byte[2:0] = filter_mode_select[2:0];
        end else if (reg_index == `ADMDR_IDX_ZONE) begin
            next_rd_byte[2:0] = zone_code;
        end else if (reg_index == `ADMDR_IDX_GAINV) begin
            next_rd_byte[6:0] = gain_value;
        end else if (reg_index == `ADMDR_IDX_DECIM) begin
            next_rd_byte[`ADMDR_BIT_DEC_EN] = decimation_ctrl_enable;
        end else if (reg_index == `ADMDR_IDX_ZONE_EN) begin
            next_rd_byte[`ADMDR_BIT_ZONE_EN] = zone_enable;
        end else if (reg_index == `ADMDR_IDX_GAIN_CTL) begin
            next_rd_byte[`ADMDR_BIT_GAIN_EN] = gain_enable;
        end else if (reg_index == `ADMDR_IDX_REO_MAP) begin
            next_rd_byte = lane_reorder_map;
        end else if (reg_index == `ADMDR_IDX_LSB_EN) begin
            next_rd_byte[`ADMDR_BIT_LSB_EN] = low_bit_enable;
        end else if (reg_index == `ADMDR_IDX_LSB_SRC) begin
            next_rd_byte[1:0] = low_bit_source;
        end else if (reg_index == `ADMDR_IDX_STATUS) begin
            next_rd_byte = {fast_overrange_flag, logic_block_reset,
                            replace_lsb, reorder_active,
                            zone_select_active, filter_mode_bad,
                            filter_highpass};
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // reserved bits are dropped; software must write them as zero
    always @(posedge mclk) begin
        if (rst) begin
            decimation_ctrl_enable <= 1'b0; // R8
        end else if (wr_commit && reg_index == `ADMDR_IDX_DECIM) begin
            decimation_ctrl_enable <= wr_byte[`ADMDR_BIT_DEC_EN];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            filter_mode_select <= 4'h0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_FMODE) begin
            filter_mode_select <= {wr_byte[`ADMDR_BIT_FMODE_HI],
                                   wr_byte[2:0]};
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            zone_enable <= 1'b0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_ZONE_EN) begin
            zone_enable <= wr_byte[`ADMDR_BIT_ZONE_EN];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            zone_code <= 3'h0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_ZONE) begin
            zone_code <= wr_byte[2:0];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            gain_value <= 7'h00;
        end else if (wr_commit && reg_index == `ADMDR_IDX_GAINV) begin
            gain_value <= wr_byte[6:0];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            gain_enable     <= 1'b0;
            reorder_wo_gain <= 1'b0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_GAIN_CTL) begin
            gain_enable     <= wr_byte[`ADMDR_BIT_GAIN_EN];
            reorder_wo_gain <= wr_byte[`ADMDR_BIT_REO_A]; // R4
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            reorder_wo_comp <= 1'b0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_REO_COMP) begin
            reorder_wo_comp <= wr_byte[`ADMDR_BIT_REO_B]; // R4
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            lane_reorder_map <= `ADMDR_RST_BYTE;
        end else if (wr_commit && reg_index == `ADMDR_IDX_REO_MAP) begin
            lane_reorder_map <= wr_byte;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            low_bit_enable <= 1'b0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_LSB_EN) begin
            low_bit_enable <= wr_byte[`ADMDR_BIT_LSB_EN];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            low_bit_source <= 2'h0;
        end else if (wr_commit && reg_index == `ADMDR_IDX_LSB_SRC) begin
            low_bit_source <= wr_byte[1:0];
        end
    end

    // ------------------------------------------------------------
    // self-clearing logic reset
    // ------------------------------------------------------------
    // one-cycle pulse; a later write of 1 fires it again
    always @(posedge mclk) begin
        if (rst) begin
            reset_pending     <= 1'b0;
            logic_block_reset <= 1'b0;
        end else begin
            reset_pending <= wr_commit &&
                             reg_index == `ADMDR_IDX_DIG_RST &&
                             wr_byte[`ADMDR_BIT_DIG_RST]; // R7
            logic_block_reset <= reset_pending && !logic_block_reset; // R12
        end
    end

    // ------------------------------------------------------------
    // datapath steering
    // ------------------------------------------------------------
    // zone state sits outside the logic reset on purpose: the
    // interleave correction must keep its setting across it
    always @(posedge mclk) begin
        if (rst) begin
            zone_select_active <= 1'b0;
            zone_applied       <= `ADMDR_ZONE_FIRST;
        end else begin
            zone_select_active <= zone_enable; // R2
            if (zone_enable && zone_code <= `ADMDR_ZONE_THIRD) begin
                zone_applied <= zone_code; // R10
            end else begin
                zone_applied <= `ADMDR_ZONE_FIRST; // R2
            end
        end
    end

    always @(posedge mclk) begin
        if (rst || logic_block_reset) begin
            filter_highpass      <= 1'b0;
            filter_mode_bad      <= 1'b0;
            gain_active          <= 1'b0;
            gain_applied         <= `ADMDR_GAIN_UNITY;
            reorder_active       <= 1'b0;
            lane_reorder_map_out <= `ADMDR_RST_BYTE;
            replace_lsb          <= 1'b0;
        end else begin
            // unsupported codes fall back to low-pass and raise a flag
            filter_highpass <= decimation_ctrl_enable &&
                filter_mode_select == `ADMDR_FMODE_HP; // R1 R9
            filter_mode_bad <= decimation_ctrl_enable &&
                filter_mode_select != `ADMDR_FMODE_HP &&
                filter_mode_select != `ADMDR_FMODE_LP; // R9
            gain_active <= gain_enable; // R3
            // unity code 32 gives 0 dB downstream
            gain_applied <= gain_enable ? gain_value
                                        : `ADMDR_GAIN_UNITY; // R3 R11
            reorder_active <= reorder_wo_gain && reorder_wo_comp; // R4
            lane_reorder_map_out <= (reorder_wo_gain && reorder_wo_comp)
                ? lane_reorder_map : `ADMDR_RST_BYTE; // R4
            replace_lsb <= low_bit_enable &&
                low_bit_source == `ADMDR_LSB_FAST_OVERRANGE_FLAG; // R5 R6
        end
    end

    // ------------------------------------------------------------
    // output channels
    // ------------------------------------------------------------
    admdr_chan u_chan_a (
        .mclk                (mclk),
        .rst                 (rst),
        .clr                 (logic_block_reset),
        .data_in             (ch_a_data_in),
        .fast_overrange_flag (fast_overrange_flag[0]),
        .replace_lsb         (replace_lsb),
        .data_out            (ch_a_data_out)
    );

    admdr_chan u_chan_b (
        .mclk                (mclk),
        .rst                 (rst),
        .clr                 (logic_block_reset),
        .data_in             (ch_b_data_in),
        .fast_overrange_flag (fast_overrange_flag[1]),
        .replace_lsb         (replace_lsb),
        .data_out            (ch_b_data_out)
    );

endmodule // admdr_regs

/* bench/admdr_regs_chk.sv */
// assertions for the main digital control register bank
`timescale 1ns/100ps
`include "admdr_defines.vh"
module admdr_regs_chk (
    input wire        mclk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        filter_highpass,
    input wire        filter_mode_bad,
    input wire        zone_select_active,
    input wire [2:0]  zone_applied,
    input wire        reorder_active,
    input wire [7:0]  lane_reorder_map_out,
    input wire        logic_block_reset
);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire [7:0] idx = wb_adr_i[9:2];
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rst_wr;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
            && idx == `ADMDR_IDX_DIG_RST && wb_dat_i[0];
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    chk_ack_follows: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_wo_reads_zero: assert property (
        wb_ack_o && !wb_we_i && idx == `ADMDR_IDX_DIG_RST
            |-> wb_dat_o == 32'h0)
        else $error("write-only register read nonzero");
    chk_mode_exclusive: assert property (
        filter_highpass |-> !filter_mode_bad)
        else $error("highpass and bad mode together");
    chk_zone_range: assert property (zone_applied <= 3'h2)
        else $error("unused zone code applied");
    chk_zone_gated: assert property (
        zone_applied != 3'h0 |-> zone_select_active)
        else $error("zone applied while disabled");
    chk_reorder_gated: assert property (
        !reorder_active |-> lane_reorder_map_out == 8'h00)
        else $error("reorder map out while inactive");
    chk_rst_pulse: assert property (
        logic_block_reset |=> !logic_block_reset)
        else $error("logic reset did not clear");
    chk_rst_cause: assert property (
        s_rst_wr |-> ##[1:3] logic_block_reset)
        else $error("logic reset missing after write");
endmodule // admdr_regs_chk

/* bench/admdr_regs_tb_top.sv */
// self-checking testbench for the main digital control register bank
`timescale 1ns/100ps
`include "admdr_defines.vh"
module admdr_regs_tb_top;
    reg         mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
    reg  [31:0] wb_adr_i, wb_dat_i;
    reg  [3:0]  wb_sel_i;
    reg  [15:0] ch_a_data_in, ch_b_data_in;
    reg  [1:0]  fast_overrange_pin;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, filter_highpass, filter_mode_bad;
    wire        zone_select_active, gain_active, reorder_active;
    wire        logic_block_reset;
    wire [15:0] ch_a_data_out, ch_b_data_out;
    wire [2:0]  zone_applied;
    wire [6:0]  gain_applied;
    wire [7:0]  lane_reorder_map_out;
    integer     errors, n_checks, k;
    reg  [31:0] q;
    admdr_regs i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ch_a_data_in(ch_a_data_in),
        .ch_b_data_in(ch_b_data_in), .fast_overrange_pin(fast_overrange_pin),
        .ch_a_data_out(ch_a_data_out), .ch_b_data_out(ch_b_data_out),
        .filter_highpass(filter_highpass), .filter_mode_bad(filter_mode_bad),
        .zone_select_active(zone_select_active), .zone_applied(zone_applied),
        .gain_active(gain_active), .gain_applied(gain_applied),
        .reorder_active(reorder_active),
        .lane_reorder_map_out(lane_reorder_map_out),
        .logic_block_reset(logic_block_reset));
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask
    // entered just after a rising edge; waits on ack, never a fixed count
    task bus(input [7:0] idx, input w, input [7:0] d);
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= w;
            wb_adr_i <= {22'h0, idx, 2'b00};
            wb_sel_i <= 4'hF;
            wb_dat_i <= {24'h0, d};
            @(posedge mclk);
            // only the watchdog ends a wait that never sees ack
            while (wb_ack_o !== 1'b1) begin
                @(posedge mclk);
            end
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        begin
            bus(idx, 1'b1, d);
            repeat (3) @(posedge mclk);
        end
    endtask
    task rd(input [7:0] idx, input [7:0] exp);
        begin
            bus(idx, 1'b0, 8'h00);
            chk(q, {24'h0, exp});
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        begin
            rd(`ADMDR_IDX_DECIM, 8'h00);
            rd(`ADMDR_IDX_ZONE_EN, 8'h00);
            rd(`ADMDR_IDX_GAIN_CTL, 8'h00);
            rd(`ADMDR_IDX_LSB_EN, 8'h00);
            rd(`ADMDR_IDX_LSB_SRC, 8'h00);
            rd(8'h10, 8'h00);
            chk(gain_applied, 32'h20);
            $display("test reset done");
        end
    endtask
    task t_filter;
        begin
            wr(`ADMDR_IDX_FMODE, 8'h16);
            chk(filter_highpass, 32'h0);
            wr(`ADMDR_IDX_DECIM, 8'h08);
            rd(`ADMDR_IDX_DECIM, 8'h08);
            chk(filter_highpass, 32'h1);
            wr(`ADMDR_IDX_FMODE, 8'h12);
            rd(`ADMDR_IDX_FMODE, 8'h12);
            chk({filter_highpass, filter_mode_bad}, 32'h0);
            wr(`ADMDR_IDX_FMODE, 8'h05);
            chk(filter_mode_bad, 32'h1);
            wr(`ADMDR_IDX_DECIM, 8'h00);
            chk(filter_mode_bad, 32'h0);
            $display("test filter done");
        end
    endtask
    task t_zone_gain;
        begin
            wr(`ADMDR_IDX_ZONE, 8'h02);
            chk(zone_applied, 32'h0);
            wr(`ADMDR_IDX_ZONE_EN, 8'h80);
            chk({zone_select_active, zone_applied}, 32'hA);
            wr(`ADMDR_IDX_ZONE, 8'h05);
            rd(`ADMDR_IDX_ZONE, 8'h05);
            chk({zone_select_active, zone_applied}, 32'h8);
            wr(`ADMDR_IDX_ZONE, 8'h02);
            wr(`ADMDR_IDX_GAINV, 8'h7F);
            rd(`ADMDR_IDX_GAINV, 8'h7F);
            chk(gain_applied, 32'h20);
            wr(`ADMDR_IDX_GAIN_CTL, 8'h81);
            rd(`ADMDR_IDX_GAIN_CTL, 8'h01);
            chk({gain_active, gain_applied}, 32'hFF);
            chk(reorder_active, 32'h0);
            wr(`ADMDR_IDX_REO_MAP, 8'h5A);
            wr(`ADMDR_IDX_REO_COMP, 8'h08);
            rd(`ADMDR_IDX_REO_COMP, 8'h00);
            chk({reorder_active, lane_reorder_map_out}, 32'h15A);
            $display("test zone gain reorder done");
        end
    endtask
    task t_lsb;
        begin
            ch_a_data_in <= 16'h1234;
            ch_b_data_in <= 16'hABCD;
            fast_overrange_pin <= 2'b01;
            wr(`ADMDR_IDX_LSB_SRC, 8'h03);
            repeat (4) @(posedge mclk);
            chk({ch_a_data_out, ch_b_data_out}, 32'h1234ABCD);
            wr(`ADMDR_IDX_LSB_EN, 8'h01);
            repeat (4) @(posedge mclk);
            chk({ch_a_data_out, ch_b_data_out}, 32'h1235ABCC);
            // lsb of data now opposite to each flag, so replacement shows
            ch_a_data_in <= 16'h1235;
            ch_b_data_in <= 16'hABCC;
            fast_overrange_pin <= 2'b10;
            repeat (8) @(posedge mclk);
            chk({ch_a_data_out, ch_b_data_out}, 32'h1234ABCD);
            wr(`ADMDR_IDX_LSB_SRC, 8'h00);
            repeat (4) @(posedge mclk);
            chk({ch_a_data_out, ch_b_data_out}, 32'h1235ABCC);
            $display("test low bit done");
        end
    endtask
    // a second write must fire again: bit is self-clearing
    task t_logic_block_reset;
        integer i, hits, zeros;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                hits = 0;
                zeros = 0;
                bus(`ADMDR_IDX_DIG_RST, 1'b1, 8'h01);
                for (k = 0; k < 6; k = k + 1) begin
                    @(posedge mclk);
                    if (logic_block_reset === 1'b1) hits = hits + 1;
                    if (ch_a_data_out === 16'h0000) zeros = zeros + 1;
                end
                chk(hits, 32'h1);
                chk(zeros, 32'h1);
                chk(zone_applied, 32'h2);
                rd(`ADMDR_IDX_DIG_RST, 8'h00);
            end
            $display("test logic reset done");
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // clock, reset, sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors = errors + 1;
        test_done;
    end
    initial begin
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        ch_a_data_in = 16'h0;
        ch_b_data_in = 16'h0;
        fast_overrange_pin = 2'b00;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_filter;
        t_zone_gain;
        t_lsb;
        t_logic_block_reset;
        test_done;
    end
endmodule // admdr_regs_tb_top
bind admdr_regs admdr_regs_chk i_chk (.mclk(mclk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .filter_highpass(filter_highpass), .filter_mode_bad(filter_mode_bad),
    .zone_select_active(zone_select_active), .zone_applied(zone_applied),
    .reorder_active(reorder_active),
    .lane_reorder_map_out(lane_reorder_map_out),
    .logic_block_reset(logic_block_reset));
